// File: nvrtc_regs.svh
// Offsets, field positions, reset values and timing counts of the memory clock block
`ifndef NVRTC_REGS_SVH
`define NVRTC_REGS_SVH

// ==========================================================================
// Bus geometry
`define ADDR_W            17
`define SEQ_ADDR_W        16

// ==========================================================================
// Clock register byte addresses (top 16 bytes of the space)
`define RTC_BASE          17'h1FFF0
`define OFF_FLAGS         17'h1FFF0
`define OFF_CENTURY       17'h1FFF6
`define OFF_CAL           17'h1FFF8
`define OFF_SECONDS       17'h1FFF9
`define OFF_YEAR          17'h1FFFF

// ==========================================================================
// Flags and calibration fields
`define FLAG_READ_BIT     0
`define FLAG_WRITE_BIT    1
`define FLAGS_MASK        8'h03
`define FLAGS_RESET       8'h00
`define CAL_OSC_OFF_BIT   7
`define CAL_RESET         8'h00

// ==========================================================================
// Time registers: usable bits per field (century..second) and base time
`define TIME_MASKS        64'hFF_FF_1F_3F_07_3F_7F_7F
`define TIME_RESET        64'h20_00_01_01_01_00_00_00
`define BCD_SEC_MAX       8'h59
`define BCD_HOUR_MAX      8'h23
`define BCD_DAY_MAX       8'h07
`define BCD_MONTH_MAX     8'h12
`define BCD_YEAR_MAX      8'h99

// ==========================================================================
// Save and restore address sequence (low 16 address bits)
`define SEQ_A0            16'h4E38
`define SEQ_A1            16'hB1C7
`define SEQ_A2            16'h83E0
`define SEQ_A3            16'h7C1F
`define SEQ_A4            16'h703F
`define SEQ_SAVE          16'h8FC0
`define SEQ_RESTORE       16'h4C63

// ==========================================================================
// Timing: one-second step at the 250 MHz system clock
`define CLK_HZ            250000000
`define SEC_PERIOD_S      1
`define SEC_CYCLES        (`CLK_HZ * `SEC_PERIOD_S)

`endif

// File: nvrtc_pkg.sv
// Types shared by the memory clock block
package nvrtc_pkg;
`include "nvrtc_regs.svh"

  // Time of day and date, all fields BCD, second in the low byte
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } bcd_time_s;

  // Parallel bus pins as seen by the device
  typedef struct packed {
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic                supply_low;
    logic [`ADDR_W-1:0]  addr;
    logic [7:0]          data;
  } bus_pins_s;

  // Position in the six-read sequence
  typedef enum logic [5:0] {
    SEQ_0 = 6'h01,
    SEQ_1 = 6'h02,
    SEQ_2 = 6'h04,
    SEQ_3 = 6'h08,
    SEQ_4 = 6'h10,
    SEQ_5 = 6'h20
  } seq_state_e;

endpackage

// File: nv_seq_detect.sv
// Six-read address sequence detector for save and restore
`timescale 1ns/1ps
`include "nvrtc_regs.svh"

module nv_seq_detect
  import nvrtc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   access,
  input  wire logic                   is_read,
  input  wire logic [`SEQ_ADDR_W-1:0] addr_low16,
  output logic                        fire,
  output logic                        store_start,
  output logic                        recall_start
);

  typedef struct packed {
    seq_state_e st;
    logic       store;
    logic       recall;
  } det_s;

  det_s q;
  det_s next_q;

  // Expected address for the current step
  function automatic logic [`SEQ_ADDR_W-1:0] step_addr(input seq_state_e s);
    case (s)
      SEQ_1:   step_addr = `SEQ_A1;
      SEQ_2:   step_addr = `SEQ_A2;
      SEQ_3:   step_addr = `SEQ_A3;
      SEQ_4:   step_addr = `SEQ_A4;
      default: step_addr = `SEQ_A0;
    endcase
  endfunction

  // A stray access restarts, but may itself be the first step again
  always_comb begin
    next_q        = q;
    next_q.store  = 1'b0;
    next_q.recall = 1'b0;
    fire          = 1'b0;
    if (access) begin
      if (!is_read) begin
        next_q.st = SEQ_0;
      end else if (q.st == SEQ_5) begin
        next_q.store  = (addr_low16 == `SEQ_SAVE);
        next_q.recall = (addr_low16 == `SEQ_RESTORE);
        fire          = next_q.store | next_q.recall;
        next_q.st     = (!fire && addr_low16 == `SEQ_A0) ? SEQ_1 : SEQ_0;
      end else if (addr_low16 == step_addr(q.st)) begin
        next_q.st = seq_state_e'({q.st[4:0], 1'b0});
      end else begin
        next_q.st = (addr_low16 == `SEQ_A0) ? SEQ_1 : SEQ_0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.st     <= SEQ_0;
      q.store  <= 1'b0;
      q.recall <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign store_start  = q.store;
  assign recall_start = q.recall;

endmodule

// File: rtc_counter.sv
// Running BCD calendar counters behind the visible time registers
`timescale 1ns/1ps
`include "nvrtc_regs.svh"

module rtc_counter
  import nvrtc_pkg::*;
#(
  parameter int TICKS_PER_SEC = `SEC_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      osc_run,
  input  wire logic      load,
  input  wire bcd_time_s load_time,
  output bcd_time_s      now
);

  localparam int DIV_W = $clog2(TICKS_PER_SEC);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    bcd_time_s        t;
  } cnt_s;

  cnt_s q;
  cnt_s next_q;

  // One BCD step between lo and hi; bit 8 is the carry out
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v >= hi)
      bcd_step = {1'b1, lo};
    else if (v[3:0] == 4'h9)
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      bcd_step = {1'b0, v + 8'h01};
  endfunction

  // BCD value divisible by four: (2*tens + ones) mod 4 == 0
  function automatic logic bcd_div4(input logic [7:0] v);
    bcd_div4 = !v[0] && (v[1] == v[4]);
  endfunction

  // Month length, with the leap rule carried into the century digits
  function automatic logic [7:0] month_len(input bcd_time_s t);
    logic leap;
    leap = (t.year == 8'h00) ? bcd_div4(t.century) : bcd_div4(t.year);
    case (t.month)
      8'h02:   month_len = leap ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction

  // Divider gives the one-second enable; the carry ripples up the fields
  always_comb begin
    logic [8:0] r;
    logic       c;
    r      = '0;
    c      = 1'b0;
    next_q = q;
    if (load) begin
      next_q.t   = load_time;
      next_q.div = '0;
    end else if (osc_run) begin
      if (q.div == DIV_W'(TICKS_PER_SEC - 1)) begin
        next_q.div = '0;
        c          = 1'b1;
      end else begin
        next_q.div = q.div + DIV_W'(1);
      end
    end
    if (c) begin
      r = bcd_step(q.t.second, 8'h00, `BCD_SEC_MAX);
      next_q.t.second = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_step(q.t.minute, 8'h00, `BCD_SEC_MAX);
      next_q.t.minute = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_step(q.t.hour, 8'h00, `BCD_HOUR_MAX);
      next_q.t.hour = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_step(q.t.day, 8'h01, `BCD_DAY_MAX);
      next_q.t.day = r[7:0];
      r = bcd_step(q.t.date, 8'h01, month_len(q.t));
      next_q.t.date = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_step(q.t.month, 8'h01, `BCD_MONTH_MAX);
      next_q.t.month = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_step(q.t.year, 8'h00, `BCD_YEAR_MAX);
      next_q.t.year = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_step(q.t.century, 8'h00, `BCD_YEAR_MAX);
      next_q.t.century = r[7:0];
    end
  end

  // Counters never see the bus supply: they keep running on backup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.div <= '0;
      q.t   <= `TIME_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign now = q.t;

endmodule

// File: nv_sram_rtc_bus_access.sv
// Bus decode, sequence trigger and double-buffered clock registers of the memory
`timescale 1ns/1ps
`include "nvrtc_regs.svh"

// Operation
// - Chip select high: ignore bus, data pins released, standby.
// - Six reads from 0x4E38 list; 0x8FC0 ends in save, 0x4C63 in restore.
// - Sequence compares only the low 16 address bits.
// - Sequence reads drive data only with output strobe low; sixth stays released.
// - Clock registers replace memory at 0x1FFF0, 0x1FFF6 and 0x1FFF8 through 0x1FFFF.
// - Visible registers are a buffer over the running counters.
// - Clock values are held and shown in BCD.
// - Count seconds up to 9999 years with weekday, months, leap and centuries.
// - Eight time registers, written and read by normal bus cycles.
// - Unused time register bits read as zero.
// - Read-hold bit freezes visible registers; counters keep running.
// - Clearing read-hold refreshes all visible registers together within 20 ms.
// - Freezing loses or delays no counts.
// - Set-hold bit stops updates and lets host write new time.
// - Host writes 24-hour BCD; written base time is kept and counted from.
// - Clearing set-hold loads written values into the counters.
// - Clock keeps running from backup when the main supply is low.
// - Oscillator-off bit is active high; zero runs, zero after reset.
module nv_sram_rtc_bus_access
  import nvrtc_pkg::*;
#(
  parameter int ADDR_W        = `ADDR_W,
  parameter int MEM_DEPTH     = 131072,
  parameter int TICKS_PER_SEC = `SEC_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        dq_in,
  output logic [7:0]             dq_out,
  output logic                   dq_oe_n,
  input  wire logic              supply_low,
  output logic                   standby,
  output logic                   nv_store_start,
  output logic                   nv_recall_start,
  output logic                   osc_running
);

  localparam bus_pins_s IDLE_PINS = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                      supply_low: 1'b0, addr: '0, data: '0};
  localparam logic [63:0] TIME_MASKS = `TIME_MASKS;

  // ==========================================================================
  // State
  typedef struct packed {
    bus_pins_s          s1;
    bus_pins_s          s2;
    bus_pins_s          s3;
    bus_pins_s          pin;
    bus_pins_s          prev;
    logic [7:0]         flags;
    logic [7:0]         cal;
    bcd_time_s          vis;
    logic               load;
    logic               wr_pend;
    logic [`ADDR_W-1:0] wr_addr;
    logic [7:0]         wr_data;
    logic               seq_hiz;
    logic               drive;
    logic [7:0]         dout;
  } top_s;

  top_s       q;
  top_s       next_q;
  logic [7:0] mem [MEM_DEPTH];
  logic       mem_we;
  bus_pins_s  raw;
  bcd_time_s  now;
  logic       sel;
  logic       prev_sel;
  logic       access;
  logic       writing;
  logic       fire;
  logic [3:0] rd_slot;
  logic [3:0] wr_slot;

  // Time register slot: bit 3 valid, low bits index seconds (0) to century (7)
  function automatic logic [3:0] time_slot(input logic [`ADDR_W-1:0] a);
    if (a == `OFF_CENTURY)
      time_slot = 4'hF;
    else if (a >= `OFF_SECONDS && a <= `OFF_YEAR)
      time_slot = {1'b1, 3'(a - `OFF_SECONDS)};
    else
      time_slot = 4'h0;
  endfunction

  // ==========================================================================
  // Pins and bus events
  assign raw = '{ce_n: ce_n, we_n: we_n, oe_n: oe_n, supply_low: supply_low,
                 addr: addr, data: dq_in};

  // Accesses start on select, on an address change or on a falling write strobe
  assign sel      = !q.pin.ce_n && !q.pin.supply_low;
  assign prev_sel = !q.prev.ce_n && !q.prev.supply_low;
  assign access   = sel && (!prev_sel || q.prev.addr != q.pin.addr ||
                            (q.prev.we_n && !q.pin.we_n));
  assign writing  = sel && !q.pin.we_n;
  assign rd_slot  = time_slot(q.pin.addr);
  assign wr_slot  = time_slot(q.wr_addr);

  // ==========================================================================
  // Sequence detector and running counters
  nv_seq_detect u_seq (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .access       (access),
    .is_read      (q.pin.we_n),
    .addr_low16   (q.pin.addr[`SEQ_ADDR_W-1:0]),
    .fire         (fire),
    .store_start  (nv_store_start),
    .recall_start (nv_recall_start)
  );

  rtc_counter #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_cnt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .osc_run   (osc_running),
    .load      (q.load),
    .load_time (q.vis),
    .now       (now)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_q = q;
    mem_we = 1'b0;
    next_q.load = 1'b0;

    // Three-stage capture; a bit moves only when stages two and three agree
    next_q.s1   = raw;
    next_q.s2   = q.s1;
    next_q.s3   = q.s2;
    next_q.pin  = bus_pins_s'((q.s2 & q.s3) | (q.pin & (q.s2 | q.s3)));
    next_q.prev = q.pin;

    // Refresh visible copy every cycle unless held; the cycle of a load is
    // skipped so the stale counter value never shows after a set
    if (!q.flags[`FLAG_READ_BIT] && !q.flags[`FLAG_WRITE_BIT] && !q.load) begin
      next_q.vis = now;
    end

    // Writes are committed when the write cycle ends, with the last data seen
    if (writing) begin
      next_q.wr_pend = 1'b1;
      next_q.wr_addr = q.pin.addr;
      next_q.wr_data = q.pin.data;
    end else if (q.wr_pend) begin
      next_q.wr_pend = 1'b0;
      if (q.wr_addr == `OFF_FLAGS) begin
        next_q.flags = q.wr_data & `FLAGS_MASK;
        if (q.flags[`FLAG_WRITE_BIT] && !q.wr_data[`FLAG_WRITE_BIT]) begin
          next_q.load = 1'b1;
        end
      end else if (q.wr_addr == `OFF_CAL) begin
        next_q.cal = q.wr_data;
      end else if (wr_slot[3]) begin
        // Time bytes only take while set-hold is on; otherwise dropped
        if (q.flags[`FLAG_WRITE_BIT]) begin
          next_q.vis[{wr_slot[2:0], 3'b000} +: 8] =
            q.wr_data & TIME_MASKS[{wr_slot[2:0], 3'b000} +: 8];
        end
      end else begin
        mem_we = 1'b1;
      end
    end

    // Read data: clock registers shadow memory in the top 16 bytes
    if (q.pin.addr == `OFF_FLAGS) begin
      next_q.dout = q.flags;
    end else if (q.pin.addr == `OFF_CAL) begin
      next_q.dout = q.cal;
    end else if (rd_slot[3]) begin
      next_q.dout = q.vis[{rd_slot[2:0], 3'b000} +: 8];
    end else begin
      next_q.dout = mem[q.pin.addr[ADDR_W-1:0]];
    end

    // Sixth sequence read keeps the pins released until the next access
    if (fire) begin
      next_q.seq_hiz = 1'b1;
    end else if (access || !sel) begin
      next_q.seq_hiz = 1'b0;
    end

    // Drive only on a selected read with the output strobe low
    next_q.drive = sel && q.pin.we_n && !q.pin.oe_n && !next_q.seq_hiz;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q         <= '0;
      q.s1      <= IDLE_PINS;
      q.s2      <= IDLE_PINS;
      q.s3      <= IDLE_PINS;
      q.pin     <= IDLE_PINS;
      q.prev    <= IDLE_PINS;
      q.flags   <= `FLAGS_RESET;
      q.cal     <= `CAL_RESET;
      q.vis     <= `TIME_RESET;
    end else begin
      q <= next_q;
    end
  end

  // Plain storage has no reset: its content comes only from bus writes
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[q.wr_addr[ADDR_W-1:0]] <= q.wr_data;
    end
  end

  // ==========================================================================
  // Outputs
  assign dq_out      = q.dout;
  assign dq_oe_n     = !q.drive;
  assign standby     = !sel;
  assign osc_running = !q.cal[`CAL_OSC_OFF_BIT];

endmodule

// File: nv_sram_rtc_bus_access_properties.sv
// Port-level assertions for the memory clock bus block
`timescale 1ns/1ps
module nv_sram_rtc_bus_access_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic supply_low,
  input wire logic dq_oe_n,
  input wire logic standby,
  input wire logic nv_store_start,
  input wire logic nv_recall_start,
  input wire logic osc_running
);
  // ==========================================================================
  // Clocking: six cycles covers the pin filter plus the output register
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_desel_release; ce_n [*6] |-> dq_oe_n; endproperty
  property p_desel_standby; ce_n [*6] |-> standby; endproperty
  property p_oe_release; oe_n [*6] |-> dq_oe_n; endproperty
  property p_write_release; (!ce_n && !we_n) [*6] |-> dq_oe_n; endproperty
  property p_supply_release; supply_low [*6] |-> dq_oe_n; endproperty
  property p_one_op; nv_store_start |-> !nv_recall_start; endproperty
  property p_store_pulse; nv_store_start |=> !nv_store_start; endproperty
  property p_recall_pulse; nv_recall_start |=> !nv_recall_start; endproperty
  property p_sixth_released;
    (nv_store_start || nv_recall_start) |-> dq_oe_n ##1 dq_oe_n;
  endproperty
  property p_write_no_start;
    (!we_n) [*6] |-> !(nv_store_start || nv_recall_start);
  endproperty
  property p_osc_after_reset; $past(sys_rst) |-> osc_running; endproperty

  a_desel_release: assert property (p_desel_release)
    else $error("data pins driven while deselected");
  a_desel_standby: assert property (p_desel_standby)
    else $error("standby low while deselected");
  a_oe_release: assert property (p_oe_release)
    else $error("data pins driven with output strobe high");
  a_write_release: assert property (p_write_release)
    else $error("data pins driven during a write");
  a_supply_release: assert property (p_supply_release)
    else $error("data pins driven with supply low");
  a_one_op: assert property (p_one_op)
    else $error("save and restore started together");
  a_store_pulse: assert property (p_store_pulse)
    else $error("save start longer than one cycle");
  a_recall_pulse: assert property (p_recall_pulse)
    else $error("restore start longer than one cycle");
  a_sixth_released: assert property (p_sixth_released)
    else $error("sixth sequence read drove the data pins");
  a_write_no_start: assert property (p_write_no_start)
    else $error("start pulse during a write");
  a_osc_after_reset: assert property (p_osc_after_reset)
    else $error("oscillator not running after reset");

  // Main scenarios reached
  c_store: cover property (nv_store_start);
  c_recall: cover property (nv_recall_start);
  c_read_drive: cover property (!dq_oe_n);
endmodule

bind nv_sram_rtc_bus_access nv_sram_rtc_bus_access_chk u_chk (
  .clk            (clk),
  .sys_rst        (sys_rst),
  .ce_n           (ce_n),
  .we_n           (we_n),
  .oe_n           (oe_n),
  .supply_low     (supply_low),
  .dq_oe_n        (dq_oe_n),
  .standby        (standby),
  .nv_store_start (nv_store_start),
  .nv_recall_start(nv_recall_start),
  .osc_running    (osc_running)
);

// File: host_bus_model.sv
// Host processor model driving the asynchronous memory bus
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        clk,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe_n,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic             supply_low,
  output logic [16:0]      addr,
  output logic [7:0]       dq_in
);
  // ==========================================================================
  // Idle bus: deselected, strobes high, supply good
  initial begin
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    supply_low = 1'b0;
    addr = 17'h00000;
    dq_in = 8'h00;
  end

  // Read: every pin held six cycles so the pin filter settles
  task automatic rd(input logic [16:0] a, input logic oe, output logic [7:0] d,
                    output logic oen);
    @(posedge clk);
    #1;
    addr = a;
    ce_n = 1'b0;
    we_n = 1'b1;
    oe_n = !oe;
    repeat (6) @(posedge clk);
    #1;
    d = dq_out;
    oen = dq_oe_n;
    ce_n = 1'b1;
    oe_n = 1'b1;
    addr = ~a; // Released lines never keep the last value
    repeat (5) @(posedge clk);
  endtask

  // Write: data and address held past the strobes so the commit sees them
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    dq_in = d;
    oe_n = 1'b1;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    we_n = 1'b1;
    ce_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    dq_in = ~d;
    addr = ~a;
  endtask

  // Main supply level
  task automatic set_supply(input logic v);
    @(posedge clk);
    #1;
    supply_low = v;
  endtask
endmodule

// File: tb_nv_sram_rtc_bus_access.sv
// Self-checking bench for the memory clock bus block
`timescale 1ns/1ps
`include "nvrtc_regs.svh"
module tb_nv_sram_rtc_bus_access
  import nvrtc_pkg::*;
;
  localparam int          TPS = 1000;
  localparam logic [15:0] SEQ_TBL [5] = '{`SEQ_A0, `SEQ_A1, `SEQ_A2, `SEQ_A3, `SEQ_A4};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce_n, we_n, oe_n, supply_low, dq_oe_n, o;
  logic        standby, nv_store_start, nv_recall_start, osc_running;
  logic [16:0] addr;
  logic [7:0]  dq_in, dq_out, d;
  logic [16:0] ma [4];
  logic [7:0]  md [4];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          store_cnt = 0;
  int          recall_cnt = 0;
  int          seed = 32'hE212;

  always #2 clk = ~clk;

  nv_sram_rtc_bus_access #(.TICKS_PER_SEC(TPS)) DUT (.clk(clk), .sys_rst(sys_rst),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .supply_low(supply_low), .standby(standby),
    .nv_store_start(nv_store_start), .nv_recall_start(nv_recall_start),
    .osc_running(osc_running));
  host_bus_model u_host (.clk(clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .supply_low(supply_low), .addr(addr), .dq_in(dq_in));

  // Count start pulses so sequences can be judged afterwards
  always @(posedge clk) begin
    store_cnt <= store_cnt + int'(nv_store_start === 1'b1);
    recall_cnt <= recall_cnt + int'(nv_recall_start === 1'b1);
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished, %0d mismatches so far", n, error_cnt);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Six reads; a write after the third breaks the chain, so the last read is plain
  task automatic run_seq(input logic [15:0] last, input logic top, input logic oe,
                         input logic brk);
    for (int i = 0; i < 6; i++) begin
      if (brk && i == 3) u_host.wr(17'h00100, 8'h5A);
      u_host.rd({top, (i < 5) ? SEQ_TBL[i] : last}, oe, d, o);
      chk({7'h0, o}, {7'h0, !(oe && (i < 5 || brk))});
    end
    repeat (4) @(posedge clk);
  endtask

  // A hang is cut short here
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    @(posedge clk);
    #1;
    chk({6'h0, dq_oe_n, standby}, 8'h03);
    chk({7'h0, osc_running}, 8'h01);
    done("reset");
    // Random bytes in four distinct quarters of the low memory
    for (int i = 0; i < 4; i++) begin
      ma[i] = {1'b0, 2'(i), 14'($random(seed))};
      md[i] = 8'($random(seed));
      u_host.wr(ma[i], md[i]);
    end
    for (int i = 0; i < 4; i++) begin
      u_host.rd(ma[i], 1'b1, d, o);
      chk(d, md[i]);
      chk({7'h0, o}, 8'h00);
    end
    u_host.rd(ma[0], 1'b0, d, o);
    chk({7'h0, o}, 8'h01);
    chk({7'h0, standby}, 8'h01);
    done("memory");
    run_seq(`SEQ_SAVE, 1'b1, 1'b1, 1'b0);
    chk(8'(store_cnt), 8'h01);
    run_seq(`SEQ_RESTORE, 1'b0, 1'b0, 1'b0);
    chk(8'(recall_cnt), 8'h01);
    run_seq(`SEQ_SAVE, 1'b0, 1'b1, 1'b1);
    chk(8'(store_cnt + recall_cnt), 8'h02);
    done("sequence");
    // Set 23:59:59 with bit 7 of the seconds set, which must be dropped
    u_host.wr(`OFF_FLAGS, 8'h02);
    u_host.wr(`OFF_SECONDS, 8'hD9);
    u_host.wr(17'h1FFFA, 8'h59);
    u_host.wr(17'h1FFFB, 8'h23);
    u_host.wr(`OFF_FLAGS, 8'h00);
    u_host.wr(`OFF_FLAGS, 8'h01);
    u_host.rd(`OFF_FLAGS, 1'b1, d, o);
    chk(d, 8'h01);
    u_host.rd(`OFF_SECONDS, 1'b1, d, o);
    chk(d, 8'h59);
    u_host.rd(17'h1FFFA, 1'b1, d, o);
    chk(d, 8'h59);
    u_host.rd(17'h1FFFB, 1'b1, d, o);
    chk(d, 8'h23);
    // Frozen across more than a second, with the main supply away meanwhile
    u_host.set_supply(1'b1);
    repeat (3 * TPS / 2) @(posedge clk);
    u_host.set_supply(1'b0);
    repeat (6) @(posedge clk);
    u_host.rd(`OFF_SECONDS, 1'b1, d, o);
    chk(d, 8'h59);
    u_host.wr(`OFF_FLAGS, 8'h00);
    u_host.wr(`OFF_FLAGS, 8'h01);
    // One or two ticks have passed, both roll over to midnight
    u_host.rd(17'h1FFFB, 1'b1, d, o);
    chk(d, 8'h00);
    u_host.rd(17'h1FFFA, 1'b1, d, o);
    chk(d, 8'h00);
    u_host.rd(`OFF_SECONDS, 1'b1, d, o);
    chk({d[7:1], 1'b0}, 8'h00);
    u_host.wr(`OFF_FLAGS, 8'h00);
    done("clock");
    u_host.wr(`OFF_CAL, 8'h80);
    chk({7'h0, osc_running}, 8'h00);
    u_host.rd(`OFF_CAL, 1'b1, d, o);
    chk(d, 8'h80);
    u_host.wr(`OFF_CAL, 8'h00);
    chk({7'h0, osc_running}, 8'h01);
    done("oscillator");
    tally_and_finish();
  end
endmodule
